//--- hdl/cpu_bus_end.sv
// processor end: sequences bus states t1..t4 and drives the local bus pins
`timescale 1ns/1ps
// Behaviour
// [R1] direction to transmit after each ready cycle
// [R2] write data and strobe start in t2
// [R3] partner latches write data on strobe end
// [R4] after write drive address next; float on hold
// [R5] new cycle may follow t4 directly
// [R6] interrupt acknowledge is two read-like cycles
// [R7] lower lines float t1 through t4 on acknowledge
// [R8] upper lines keep status during acknowledge cycles
// [R9] vector read only on second acknowledge cycle
// [R10] transceiver controls released between acknowledge cycles
// [R11] acknowledge strobe has write strobe timing
// [R12] partner ready from address decode, stable
// [R13] normally ready, slow device pulls ready low
// [R14] memory/io line may request i/o waits
// [R15] test sampled during wait, held six clocks
// [R16] controller starts on status leaving passive
// [R17] latch strobe not before t1
// [R18] latch strobe ends within t1
// [R19] address held valid until end of t1
// [R20] max mode lines switch as min mode
// [R21] reads float lower lines, upper turn status
// [R22] ready sampled from t3, waits inserted
module cpu_bus_end (
   input  wire logic                 i_ref_clk,
   input  wire logic                 i_rst_n,
   input  wire logic                 i_req,
   input  wire lbus_pkg::cycle_kind_e i_kind,
   input  wire logic [19:0]          i_addr,
   input  wire logic [15:0]          i_wdata,
   input  wire logic                 i_bhe_n,
   input  wire logic                 i_if_flag,
   input  wire logic                 i_wait_exec,
   output logic                      o_req_ready,
   output logic                      o_done,
   output logic [15:0]               o_rdata,
   output logic [7:0]                o_vector,
   output logic                      o_test_seen,
   lbus_if.cpu                       bus
);
   import lbus_pkg::*;

   bus_state_e  state_reg, state_next;
   cycle_kind_e kind_reg, kind_next;
   logic [19:0] addr_reg;
   logic [15:0] wdata_reg;
   logic        bhe_reg;
   logic        second_reg, second_next;
   logic [15:0] ad_reg, ad_next;
   logic        ad_oe_reg, ad_oe_next;
   logic [3:0]  upper_reg, upper_next;
   logic        bhe_n_reg, bhe_n_next;
   logic        ale_reg;
   logic [2:0]  stat_reg, stat_next;
   logic        mem_io_reg;
   logic        rd_n_reg, wr_n_reg, irq_ack_strobe_n_n_reg;
   logic        dir_reg, dir_next;
   logic        den_n_reg;
   logic [15:0] rdata_reg;
   logic [7:0]  vector_reg;
   logic        done_reg;

   wire st_idle  = (state_reg == ST_IDLE);
   wire st_t3    = (state_reg == ST_T3);
   wire st_tw    = (state_reg == ST_TW);
   wire st_t4    = (state_reg == ST_T4);
   wire is_irq_ack_strobe_n  = (kind_reg == K_IRQ_ACK_STROBE_N);
   wire is_wr    = (kind_reg == K_MEM_WR) | (kind_reg == K_IO_WR);
   wire is_rd    = (kind_reg == K_MEM_RD) | (kind_reg == K_IO_RD);
   wire first_ia = is_irq_ack_strobe_n & ~second_reg;
   // the data phase ends on a ready sample in t3 or a wait state
   wire data_end = (st_t3 | st_tw) & bus.ready; // [R22]

   // a request is taken only where a cycle may begin and the bus is ours
   assign o_req_ready = (st_idle | (st_t4 & ~first_ia)) & ~bus.hold_req; // [R5]
   wire accept = i_req & o_req_ready;

   // bus state sequence
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (bus.hold_req) state_next = ST_HOLD;
            else if (i_req) state_next = ST_T1;
         end
         ST_T1: state_next = ST_T2;
         ST_T2: state_next = ST_T3;
         ST_T3, ST_TW: begin
            state_next = bus.ready ? ST_T4 : ST_TW; // [R22]
         end
         ST_T4: begin
            if (first_ia) state_next = ST_T1; // [R6]
            else if (bus.hold_req) state_next = ST_HOLD; // [R4]
            else if (i_req) state_next = ST_T1; // [R5]
            else state_next = ST_IDLE;
         end
         ST_HOLD: begin
            if (!bus.hold_req) state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   wire n_t1   = (state_next == ST_T1);
   wire n_t2   = (state_next == ST_T2);
   wire n_mid  = (state_next == ST_T3) | (state_next == ST_TW);
   wire n_t4   = (state_next == ST_T4);
   wire n_hold = (state_next == ST_HOLD);

   // second acknowledge cycle follows the first without a new request
   assign second_next = (st_t4 & first_ia) ? 1'b1 : (accept ? 1'b0 : second_reg); // [R6]
   assign kind_next   = accept ? i_kind : kind_reg;
   wire   k_irq_ack_strobe_n = (kind_next == K_IRQ_ACK_STROBE_N);
   wire   k_wr   = (kind_next == K_MEM_WR) | (kind_next == K_IO_WR);
   wire   k_rd   = (kind_next == K_MEM_RD) | (kind_next == K_IO_RD);
   wire   k_mem  = (kind_next == K_MEM_RD) | (kind_next == K_MEM_WR);
   wire [19:0] a_next = accept ? i_addr : addr_reg;

   wire [15:0] wdata_sel = accept ? i_wdata : wdata_reg;
   // lower lines: address in t1, write data from t2, float for reads
   // a finished write keeps its data on the lines until the next address or a hold
   assign ad_next = n_t1 ? a_next[15:0]  // [R19]
                  : ((n_t2 & k_wr) ? wdata_sel : ad_reg); // [R2]
   assign ad_oe_next = n_hold ? 1'b0 // [R4]
                     : n_t1 ? ~k_irq_ack_strobe_n // [R7]
                     : (n_t2 | n_mid | n_t4) ? k_wr // [R21] [R20]
                     : ad_oe_reg;

   // upper lines: address in t1, then status with s3, s4, s6 low, s5 = if
   assign upper_next = n_t1 ? a_next[19:16]
                     : (n_t2 | n_mid | n_t4) ? {1'b0, i_if_flag, 2'b00} // [R8] [R21]
                     : upper_reg;
   assign bhe_n_next = n_t1 ? (k_irq_ack_strobe_n ? 1'b0 : (accept ? i_bhe_n : bhe_reg)) : bhe_n_reg; // [R8]

   // status leaves passive for t1 and t2 so a controller can start the cycle
   assign stat_next = ~(n_t1 | n_t2) ? STAT_PASSIVE
                    : k_irq_ack_strobe_n ? STAT_IRQ_ACK_STROBE_N
                    : k_mem ? (k_wr ? STAT_MEM_WR : STAT_MEM_RD)
                    : (k_wr ? STAT_IO_WR : STAT_IO_RD); // [R20]

   // receive only for reads and acknowledges, transmit again from t4
   assign dir_next = ~((n_t1 | n_t2 | n_mid) & (k_rd | k_irq_ack_strobe_n)); // [R1] [R10]

   wire strobe_win = n_t2 | n_mid;
   wire den_win    = n_t2 | n_mid | n_t4;

   // cycle bookkeeping
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         state_reg  <= ST_IDLE;
         kind_reg   <= K_MEM_RD;
         addr_reg   <= 20'h00000;
         wdata_reg  <= AD_RST;
         bhe_reg    <= 1'b1;
         second_reg <= 1'b0;
      end else begin
         state_reg  <= state_next;
         kind_reg   <= kind_next;
         addr_reg   <= a_next;
         wdata_reg  <= wdata_sel;
         bhe_reg    <= accept ? i_bhe_n : bhe_reg;
         second_reg <= second_next;
      end
   end

   // pin drivers, all from flip-flops
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         ad_reg     <= AD_RST;
         ad_oe_reg  <= 1'b0;
         upper_reg  <= UPPER_RST;
         bhe_n_reg  <= 1'b1;
         ale_reg    <= 1'b0;
         stat_reg   <= STAT_PASSIVE;
         mem_io_reg <= 1'b1;
         rd_n_reg   <= 1'b1;
         wr_n_reg   <= 1'b1;
         irq_ack_strobe_n_n_reg <= 1'b1;
         dir_reg    <= 1'b1;
         den_n_reg  <= 1'b1;
      end else begin
         ad_reg     <= ad_next;
         ad_oe_reg  <= ad_oe_next;
         upper_reg  <= upper_next;
         bhe_n_reg  <= bhe_n_next;
         ale_reg    <= n_t1; // [R19]
         stat_reg   <= stat_next;
         mem_io_reg <= n_t1 ? k_mem : mem_io_reg; // [R14]
         rd_n_reg   <= ~(strobe_win & k_rd);
         wr_n_reg   <= ~(strobe_win & k_wr); // [R2]
         irq_ack_strobe_n_n_reg <= ~(strobe_win & k_irq_ack_strobe_n); // [R11]
         dir_reg    <= dir_next;
         den_n_reg  <= ~den_win; // [R10]
      end
   end

   // read data and vector are taken on the edge that leaves the data phase
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         rdata_reg  <= AD_RST;
         vector_reg <= 8'h00;
         done_reg   <= 1'b0;
      end else begin
         if (data_end & is_rd) rdata_reg <= bus.ad_bus;
         if (data_end & is_irq_ack_strobe_n & second_reg) vector_reg <= bus.ad_bus[7:0]; // [R9]
         done_reg <= data_end & ~first_ia;
      end
   end

   test_sampler u_test (
      .i_ref_clk   (i_ref_clk),
      .i_rst_n     (i_rst_n),
      .i_wait_exec (i_wait_exec),
      .i_test_n    (bus.test_n),
      .o_test_seen (o_test_seen)
   );

   assign bus.cpu_ad                  = ad_reg;
   assign bus.cpu_ad_oe               = ad_oe_reg;
   assign bus.upper_addr_status_lines = upper_reg;
   assign bus.high_byte_enable_n      = bhe_n_reg;
   assign bus.ale                     = ale_reg;
   assign bus.cycle_status_n          = stat_reg;
   assign bus.mem_io                  = mem_io_reg;
   assign bus.rd_n                    = rd_n_reg;
   assign bus.wr_n                    = wr_n_reg;
   assign bus.irq_ack_strobe_n        = irq_ack_strobe_n_n_reg;
   assign bus.xcvr_direction          = dir_reg;
   assign bus.xcvr_enable_n           = den_n_reg;
   assign bus.hold_ack                = (state_reg == ST_HOLD);
   assign o_done                      = done_reg;
   assign o_rdata                     = rdata_reg;
   assign o_vector                    = vector_reg;
endmodule : cpu_bus_end

//--- hdl/lbus_pkg.sv
// shared constants and types of the local bus cycle sequencer
package lbus_pkg;
   // bus states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'b0000001,
      ST_T1   = 7'b0000010,
      ST_T2   = 7'b0000100,
      ST_T3   = 7'b0001000,
      ST_TW   = 7'b0010000,
      ST_T4   = 7'b0100000,
      ST_HOLD = 7'b1000000
   } bus_state_e;

   // kind of bus cycle asked for by the user side
   typedef enum logic [2:0] {
      K_MEM_RD = 3'h0,
      K_MEM_WR = 3'h1,
      K_IO_RD  = 3'h2,
      K_IO_WR  = 3'h3,
      K_IRQ_ACK_STROBE_N   = 3'h4
   } cycle_kind_e;

   // cycle status codes, active low, and the passive code
   localparam logic [2:0]  STAT_IRQ_ACK_STROBE_N    = 3'h0;
   localparam logic [2:0]  STAT_IO_RD   = 3'h1;
   localparam logic [2:0]  STAT_IO_WR   = 3'h2;
   localparam logic [2:0]  STAT_MEM_RD  = 3'h5;
   localparam logic [2:0]  STAT_MEM_WR  = 3'h6;
   localparam logic [2:0]  STAT_PASSIVE = 3'h7;

   // reset values of the pin drivers, and the level of undriven lower lines
   localparam logic [15:0] AD_RST       = 16'h0000;
   localparam logic [3:0]  UPPER_RST    = 4'h0;
   localparam logic [15:0] AD_PULL      = 16'hFFFF;

   // wait states inserted by the partner for every i/o cycle
   localparam logic [3:0]  IO_WAIT_STATES = 4'h2;
   // least number of clocks the test input is held active
   localparam logic [3:0]  TEST_HOLD_CYC  = 4'h6;
endpackage : lbus_pkg

//--- hdl/lbus_if.sv
// pins of the multiplexed local bus between processor and partner
`timescale 1ns/1ps
interface lbus_if;
   import lbus_pkg::*;
   logic [15:0] cpu_ad;          // lower lines, processor driver
   logic        cpu_ad_oe;
   logic [15:0] part_ad;         // lower lines, partner driver
   logic        part_ad_oe;
   logic [15:0] ad_bus;          // resolved level
   logic [3:0]  upper_addr_status_lines;
   logic        high_byte_enable_n;
   logic        ale;
   logic [2:0]  cycle_status_n;
   logic        mem_io;
   logic        rd_n;
   logic        wr_n;
   logic        irq_ack_strobe_n;
   logic        xcvr_direction;
   logic        xcvr_enable_n;
   logic        ready;
   logic        hold_req;
   logic        hold_ack;
   logic        test_n;

   // undriven lines float high through the pull-ups
   assign ad_bus = cpu_ad_oe ? cpu_ad : (part_ad_oe ? part_ad : AD_PULL);

   modport cpu (output cpu_ad, cpu_ad_oe, upper_addr_status_lines, high_byte_enable_n, ale,
                cycle_status_n, mem_io, rd_n, wr_n, irq_ack_strobe_n, xcvr_direction,
                xcvr_enable_n, hold_ack,
                input ad_bus, ready, hold_req, test_n);
   modport partner (output part_ad, part_ad_oe, ready, hold_req, test_n,
                    input ad_bus, cpu_ad, upper_addr_status_lines, high_byte_enable_n, ale,
                    cycle_status_n, mem_io, rd_n, wr_n, irq_ack_strobe_n, xcvr_direction,
                    xcvr_enable_n, hold_ack);
endinterface : lbus_if

//--- hdl/test_sampler.sv
// samples the test input only while a wait instruction executes
`timescale 1ns/1ps
module test_sampler (
   input  wire logic i_ref_clk,
   input  wire logic i_rst_n,
   input  wire logic i_wait_exec,
   input  wire logic i_test_n,
   output logic      o_test_seen
);
   logic seen_reg;
   logic seen_next;

   // outside the wait the pin is ignored, so a short glitch there is harmless
   assign seen_next = i_wait_exec & ~i_test_n; // [R15]

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         seen_reg <= 1'b0;
      end else begin
         seen_reg <= seen_next;
      end
   end

   assign o_test_seen = seen_reg;
endmodule : test_sampler

//--- hdl/bus_partner_end.sv
// partner end: bus controller strobe, address latch, ready, vector and test logic
`timescale 1ns/1ps
module bus_partner_end (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic [15:0] i_rdata,
   input  wire logic [7:0]  i_vector,
   input  wire logic        i_hold_req,
   input  wire logic        i_test_req,
   output logic             o_latch_strobe,
   output logic [19:0]      o_addr,
   output logic [15:0]      o_wdata,
   output logic             o_wr_valid,
   output logic             o_bus_granted,
   lbus_if.partner          bus
);
   import lbus_pkg::*;

   logic [2:0]  stat_prev_reg;
   logic [19:0] addr_reg;
   logic [15:0] wdata_reg;
   logic        wr_valid_reg;
   logic        wr_n_prev_reg;
   logic        irq_ack_strobe_n_prev_reg;
   logic        second_reg;
   logic [3:0]  wait_reg, wait_next;
   logic [3:0]  test_reg;

   // strobe rises once status leaves passive and drops at the next edge, inside t1
   // a late status simply makes the pulse start late; it never starts before t1
   assign o_latch_strobe = (bus.cycle_status_n != STAT_PASSIVE) &
                           (stat_prev_reg == STAT_PASSIVE); // [R16] [R17] [R18]

   // i/o cycles get fixed waits from the memory/io line, memory none
   assign wait_next = o_latch_strobe ? (bus.mem_io ? 4'h0 : IO_WAIT_STATES + 4'h1) // [R14]
                    : ((wait_reg != 4'h0) ? wait_reg - 4'h1 : 4'h0);
   // normally ready; pulled low from the decode until the waits are spent
   assign bus.ready = (wait_reg == 4'h0); // [R12] [R13]

   // vector only on the second acknowledge, read data on read strobe
   wire drive_vec     = ~bus.irq_ack_strobe_n & second_reg; // [R9]
   assign bus.part_ad    = drive_vec ? {8'h00, i_vector} : i_rdata;
   assign bus.part_ad_oe = drive_vec | ~bus.rd_n;

   // test line held active for a fixed count so the processor cannot miss it
   assign bus.test_n   = (test_reg == 4'h0); // [R15]
   assign bus.hold_req = i_hold_req;

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         stat_prev_reg <= STAT_PASSIVE;
         addr_reg      <= 20'h00000;
         wdata_reg     <= AD_RST;
         wr_valid_reg  <= 1'b0;
         wr_n_prev_reg <= 1'b1;
         irq_ack_strobe_n_prev_reg <= 1'b1;
         second_reg    <= 1'b0;
         wait_reg      <= 4'h0;
         test_reg      <= 4'h0;
      end else begin
         stat_prev_reg <= bus.cycle_status_n;
         wr_n_prev_reg <= bus.wr_n;
         irq_ack_strobe_n_prev_reg <= bus.irq_ack_strobe_n;
         wait_reg      <= wait_next;
         // address still valid while the strobe is high in t1
         if (o_latch_strobe) addr_reg <= {bus.upper_addr_status_lines, bus.ad_bus};
         // write data taken as the strobe ends, when it is surely valid
         wr_valid_reg <= bus.wr_n & ~wr_n_prev_reg; // [R3]
         if (bus.wr_n & ~wr_n_prev_reg) wdata_reg <= bus.ad_bus; // [R3]
         // each acknowledge strobe end flips first/second
         if (bus.irq_ack_strobe_n & ~irq_ack_strobe_n_prev_reg) second_reg <= ~second_reg;
         if (i_test_req) test_reg <= TEST_HOLD_CYC;
         else if (test_reg != 4'h0) test_reg <= test_reg - 4'h1;
      end
   end

   assign o_addr        = addr_reg;
   assign o_wdata       = wdata_reg;
   assign o_wr_valid    = wr_valid_reg;
   assign o_bus_granted = bus.hold_ack;
endmodule : bus_partner_end

//--- test/lbus_props.sv
// concurrent checks on the local bus pins between processor end and partner end
`timescale 1ns/1ps
module lbus_props
   import lbus_pkg::*;
(
   input wire logic       i_ref_clk,
   input wire logic       i_rst_n,
   input wire logic       cpu_ad_oe,
   input wire logic [3:0] upper_addr_status_lines,
   input wire logic       high_byte_enable_n,
   input wire logic       ale,
   input wire logic [2:0] cycle_status_n,
   input wire logic       rd_n,
   input wire logic       wr_n,
   input wire logic       irq_ack_strobe_n,
   input wire logic       xcvr_direction,
   input wire logic       xcvr_enable_n,
   input wire logic       ready,
   input wire logic       hold_ack
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);

   // t1 decode from the status code; status is only active in t1 and t2
   wire t1_write  = ale && (cycle_status_n == STAT_MEM_WR || cycle_status_n == STAT_IO_WR);
   wire t1_read   = ale && (cycle_status_n == STAT_MEM_RD || cycle_status_n == STAT_IO_RD);
   wire t1_ack    = ale && (cycle_status_n == STAT_IRQ_ACK_STROBE_N);
   wire strobe_on = !(rd_n && wr_n && irq_ack_strobe_n);

   dir_write_a: assert property (t1_write |-> xcvr_direction [*4]) else $error("direction left transmit in write");
   wr_start_a: assert property ($fell(wr_n) |-> $past(ale) && cpu_ad_oe && !xcvr_enable_n)
      else $error("write strobe not started in t2 with data");
   ack_float_a: assert property (t1_ack |-> !cpu_ad_oe [*4]) else $error("lower lines driven in ack");
   ack_status_a: assert property (!irq_ack_strobe_n |-> !high_byte_enable_n && upper_addr_status_lines[0] == 1'b0
      && upper_addr_status_lines[1] == 1'b0 && upper_addr_status_lines[3] == 1'b0) else $error("bad ack status");
   ack_xcvr_a: assert property (t1_ack |-> xcvr_enable_n && !xcvr_direction ##1 !xcvr_enable_n)
      else $error("transceiver controls wrong in ack");
   ack_strobe_a: assert property ($fell(irq_ack_strobe_n) |-> $past(ale) ##1 !irq_ack_strobe_n ##[1:12]
      $rose(irq_ack_strobe_n)) else $error("ack strobe timing wrong");
   wait_hold_a: assert property (strobe_on && !ready |=> strobe_on) else $error("strobe ended while not ready");
   addr_hold_a: assert property (ale |-> (cpu_ad_oe || cycle_status_n == STAT_IRQ_ACK_STROBE_N) ##1 !ale)
      else $error("address not held through t1");
   ale_start_a: assert property (ale |-> cycle_status_n != STAT_PASSIVE && $past(cycle_status_n) == STAT_PASSIVE)
      else $error("latch enable without status leaving passive");
   read_float_a: assert property (t1_read |=> !cpu_ad_oe [*3]) else $error("lower lines driven in read");
   hold_float_a: assert property (hold_ack |-> !cpu_ad_oe) else $error("lower lines driven in hold");

   // main scenarios reached
   write_c: cover property (t1_write);
   ack_c: cover property (t1_ack ##[4:8] t1_ack);
   wait_c: cover property (strobe_on && !ready);
   hold_c: cover property (hold_ack);
endmodule : lbus_props

//--- test/tb_cpu_local_bus_cycle_sequencer.sv
// self-checking bench: processor end and partner end joined by the local bus
`timescale 1ns/1ps
module tb_cpu_local_bus_cycle_sequencer;
   import lbus_pkg::*;
   logic        i_ref_clk, i_rst_n, i_req, i_bhe_n, i_if_flag, i_wait_exec, o_req_ready, o_done, o_test_seen;
   cycle_kind_e i_kind;
   logic [19:0] i_addr, o_addr;
   logic [15:0] i_wdata, o_rdata, i_rdata, o_wdata;
   logic [7:0]  o_vector, i_vector;
   logic        i_hold_req, i_test_req, o_latch_strobe, o_wr_valid, o_bus_granted, prev_wr, b2b;
   int          n_mismatch, check_count, cyc, n, seed_dummy;

   lbus_if lbus_if_i ();
   cpu_bus_end cpu_bus_end_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_req(i_req), .i_kind(i_kind),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_bhe_n(i_bhe_n), .i_if_flag(i_if_flag), .i_wait_exec(i_wait_exec),
      .o_req_ready(o_req_ready), .o_done(o_done), .o_rdata(o_rdata), .o_vector(o_vector),
      .o_test_seen(o_test_seen), .bus(lbus_if_i.cpu));
   bus_partner_end bus_partner_end_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rdata(i_rdata),
      .i_vector(i_vector), .i_hold_req(i_hold_req), .i_test_req(i_test_req), .o_latch_strobe(o_latch_strobe),
      .o_addr(o_addr), .o_wdata(o_wdata), .o_wr_valid(o_wr_valid), .o_bus_granted(o_bus_granted),
      .bus(lbus_if_i.partner));
   lbus_props lbus_props_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .cpu_ad_oe(lbus_if_i.cpu_ad_oe),
      .upper_addr_status_lines(lbus_if_i.upper_addr_status_lines), .high_byte_enable_n(lbus_if_i.high_byte_enable_n),
      .ale(lbus_if_i.ale), .cycle_status_n(lbus_if_i.cycle_status_n), .rd_n(lbus_if_i.rd_n), .wr_n(lbus_if_i.wr_n),
      .irq_ack_strobe_n(lbus_if_i.irq_ack_strobe_n), .xcvr_direction(lbus_if_i.xcvr_direction),
      .xcvr_enable_n(lbus_if_i.xcvr_enable_n), .ready(lbus_if_i.ready), .hold_ack(lbus_if_i.hold_ack));

   // 50 MHz clock
   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   task automatic end_of_test();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test

   // a run needs about 650 clocks; the ceiling leaves ample slack for a hang
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 6000) begin
         n_mismatch++;
         end_of_test();
      end
   end

   task automatic chk_bit(input logic got, input logic exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: got %b", $time, what, got);
      end
   endtask : chk_bit

   task automatic chk_val(input logic [19:0] got, input logic [19:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask : chk_val

   task automatic chk_lat(input int got, input int exp, input string what);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s: got %0d want %0d", $time, what, got, exp);
      end
   endtask : chk_lat

   // clocks from t1 to done: an i/o cycle carries the partner's fixed waits; an ack is not a memory
   // cycle, so each of its two cycles carries those waits as well
   function automatic int exp_lat(input cycle_kind_e k);
      if (k == K_IRQ_ACK_STROBE_N) return 2 * (4 + int'(IO_WAIT_STATES));
      if (k == K_IO_RD || k == K_IO_WR) return 4 + int'(IO_WAIT_STATES);
      return 4;
   endfunction : exp_lat

   // raise a request with random contents, hold it until taken; ends at the t1 falling edge
   task automatic issue(input cycle_kind_e k, input logic back);
      int w;
      i_kind = k;
      i_addr = 20'($urandom);
      i_wdata = 16'($urandom);
      i_bhe_n = 1'($urandom);
      i_if_flag = 1'($urandom);
      i_rdata = 16'($urandom);
      i_vector = 8'($urandom);
      i_req = 1'b1;
      w = 0;
      while (o_req_ready !== 1'b1 && w < 20) begin
         @(negedge i_ref_clk);
         w++;
      end
      if (back) chk_lat(w, 0, "request after t4 not taken at once");
      @(negedge i_ref_clk);
      i_req = 1'b0;
      chk_bit(lbus_if_i.ale, 1'b1, "no latch enable in t1");
      chk_bit(o_latch_strobe, 1'b1, "no latch strobe in t1");
   endtask : issue

   // follow the cycle to done and check its results; a write may be followed by a hold request
   task automatic finish(input logic hold_after);
      n = 1;
      while (o_done !== 1'b1 && n < 40) begin
         @(negedge i_ref_clk);
         n++;
         if (lbus_if_i.irq_ack_strobe_n === 1'b0) chk_bit(lbus_if_i.upper_addr_status_lines[2], i_if_flag, "flag bit");
      end
      chk_lat(n, exp_lat(i_kind), "cycle length");
      if (i_kind == K_MEM_RD || i_kind == K_IO_RD) chk_val(20'(o_rdata), 20'(i_rdata), "read data");
      if (i_kind == K_IRQ_ACK_STROBE_N) chk_val(20'(o_vector), 20'(i_vector), "vector");
      prev_wr = (i_kind == K_MEM_WR || i_kind == K_IO_WR);
      if (prev_wr) begin
         i_hold_req = hold_after;
         @(negedge i_ref_clk);
         chk_bit(o_wr_valid, 1'b1, "write not captured");
         chk_val(20'(o_wdata), 20'(i_wdata), "write data");
         chk_val(o_addr, i_addr, "latched address");
         @(negedge i_ref_clk);
         chk_bit(lbus_if_i.cpu_ad_oe, ~hold_after, "lower lines after write");
         chk_bit(o_bus_granted, hold_after, "bus grant after write");
         i_hold_req = 1'b0;
      end
   endtask : finish

   initial begin
      {i_rst_n, i_req, i_bhe_n, i_if_flag, i_wait_exec, i_hold_req, i_test_req} = 7'h00;
      {i_addr, i_wdata, i_rdata, i_vector} = 60'h0;
      i_kind = K_MEM_RD;
      n_mismatch = 0;
      check_count = 0;
      seed_dummy = $urandom(32'hB8DBC12E);
      repeat (20) @(negedge i_ref_clk);
      i_rst_n = 1'b1;
      @(negedge i_ref_clk);
      // every cycle kind once, then a write followed by a hold request
      for (int k = 0; k < 5; k++) begin
         issue(cycle_kind_e'(k), 1'b0);
         finish(1'b0);
      end
      issue(K_MEM_WR, 1'b0);
      finish(1'b1);
      // requests are refused while the bus is held
      repeat (2) @(negedge i_ref_clk);
      i_hold_req = 1'b1;
      repeat (3) @(negedge i_ref_clk);
      chk_bit(o_bus_granted, 1'b1, "hold not granted");
      chk_bit(o_req_ready, 1'b0, "request accepted in hold");
      i_hold_req = 1'b0;
      repeat (3) @(negedge i_ref_clk);
      // test input seen during the wait instruction only; partner holds it the minimum time
      i_wait_exec = 1'b1;
      i_test_req = 1'b1;
      @(negedge i_ref_clk);
      i_test_req = 1'b0;
      n = 0;
      while (o_test_seen !== 1'b1 && n < 12) begin
         @(negedge i_ref_clk);
         n++;
      end
      chk_bit(o_test_seen, 1'b1, "test not seen in wait");
      repeat (10) @(negedge i_ref_clk);
      i_wait_exec = 1'b0;
      i_test_req = 1'b1;
      @(negedge i_ref_clk);
      i_test_req = 1'b0;
      // the line is already low here, half a clock after the load
      n = int'(!lbus_if_i.test_n);
      repeat (10) begin
         @(negedge i_ref_clk);
         n += int'(!lbus_if_i.test_n);
         chk_bit(o_test_seen, 1'b0, "test seen outside wait");
      end
      chk_lat(n, int'(TEST_HOLD_CYC), "test active length");
      // random traffic, back to back where the previous cycle allows
      prev_wr = 1'b1;
      repeat (60) begin
         b2b = 1'($urandom) && !prev_wr;
         if (!b2b) repeat ($urandom_range(1, 3)) @(negedge i_ref_clk);
         issue(cycle_kind_e'($urandom_range(0, 4)), b2b);
         finish(1'($urandom_range(0, 3) == 0));
      end
      end_of_test();
   end
endmodule : tb_cpu_local_bus_cycle_sequencer
